// ---- rtl/external_bus_pin_routing.v ----
// pin multiplexer for parallel and serial ports plus config regs
// Overview of operation
// - parallel port field picks 21 pin sources
// - code 000 routes full lcd bridge
// - code 001: spi, gpio, uart, third audio
// - code 010: lcd pixels and eight gpio
// - code 011: lcd pixels, spi, fourth audio
// - code 100: lcd pixels, third audio, uart
// - code 101: lcd pixels, spi, uart
// - code 110: spi, both audio, six gpio
// - serial one code 00: second card
// - serial one 01: audio plus gpio 11:10
// - serial one 10: gpio 11 to 6
// - serial zero code 00: first card
// - serial zero 01: audio plus gpio 5:4
// - serial zero 10: gpio 5 to 0
// - new routing applies next clock cycle
// - bits 15, 7, 6 read zero
// - core regulator defaults high, selectable voltage
// - usb regulator off until software enables
// - usb access word wide, byte select
`timescale 1ns/1ps
`include "pin_routing_consts.vh"

module external_bus_pin_routing (
  input  wire        sys_clk,
  input  wire        resetn,
  // cpu register port
  input  wire [15:0] io_addr,
  input  wire        io_wr_en,
  input  wire        io_rd_en,
  input  wire [15:0] io_wdata,
  output reg  [15:0] io_rdata,
  output reg         io_rd_valid,
  // parallel port pads
  input  wire [20:0] pp_pin_in,
  output wire [20:0] pp_pin_out,
  output wire [20:0] pp_pin_oe,
  // serial port pads
  input  wire [5:0]  sp0_pin_in,
  output wire [5:0]  sp0_pin_out,
  output wire [5:0]  sp0_pin_oe,
  input  wire [5:0]  sp1_pin_in,
  output wire [5:0]  sp1_pin_out,
  output wire [5:0]  sp1_pin_oe,
  // lcd bridge: [15:0] pixel data, [20:16] control
  input  wire [20:0] lcd_out,
  input  wire [20:0] lcd_oe,
  output reg  [20:0] lcd_in,
  // spi: [3:0] routed in codes 001, 011, 101, 110, [6:4] only in wide modes
  input  wire [6:0]  spi_out,
  input  wire [6:0]  spi_oe,
  output reg  [6:0]  spi_in,
  input  wire [3:0]  uart_out,
  input  wire [3:0]  uart_oe,
  output reg  [3:0]  uart_in,
  // audio serial ports
  input  wire [3:0]  first_audio_serial_port_out,
  input  wire [3:0]  first_audio_serial_port_oe,
  output reg  [3:0]  first_audio_serial_port_in,
  input  wire [3:0]  second_audio_serial_port_out,
  input  wire [3:0]  second_audio_serial_port_oe,
  output reg  [3:0]  second_audio_serial_port_in,
  input  wire [3:0]  third_audio_serial_port_out,
  input  wire [3:0]  third_audio_serial_port_oe,
  output reg  [3:0]  third_audio_serial_port_in,
  input  wire [3:0]  fourth_audio_serial_port_out,
  input  wire [3:0]  fourth_audio_serial_port_oe,
  output reg  [3:0]  fourth_audio_serial_port_in,
  // card interfaces
  input  wire [5:0]  first_card_interface_out,
  input  wire [5:0]  first_card_interface_oe,
  output reg  [5:0]  first_card_interface_in,
  input  wire [5:0]  second_card_interface_out,
  input  wire [5:0]  second_card_interface_oe,
  output reg  [5:0]  second_card_interface_in,
  // general purpose io
  input  wire [31:0] gp_out,
  input  wire [31:0] gp_oe,
  output wire [31:0] gp_in,
  // configuration outputs
  output wire [2:0]  parallel_port_route_field,
  output wire [1:0]  serial_port_one_route_field,
  output wire [1:0]  serial_port_zero_route_field,
  output wire        core_regulator_voltage_select,
  output wire        usb_regulator_enable,
  output wire [1:0]  usb_byte_access_select
);

  // ========================================================
  // state and internal nets
  reg  [2:0]  pp_mode;       // parallel port route code
  reg  [1:0]  sp1_mode;      // serial port one route code
  reg  [1:0]  sp0_mode;      // serial port zero route code
  reg         core_vsel;     // 0 = 1.3 V, 1 = 1.05 V
  reg         usb_reg_en;    // usb regulator on
  reg  [1:0]  byte_sel;      // usb byte access code
  reg  [15:0] next_rdata;    // read mux result
  reg  [7:0]  pp_gp_in;      // gpio bits seen on parallel port
  reg  [5:0]  sp0_gp_in;     // gpio 5:0 seen on serial zero
  reg  [5:0]  sp1_gp_in;     // gpio 11:6 seen on serial one
  wire [32:0] pins_sync;     // synchronised pad inputs
  wire [20:0] pp_in;         // parallel port pads, synced
  wire [5:0]  sp0_in;        // serial zero pads, synced
  wire [5:0]  sp1_in;        // serial one pads, synced
  wire [20:0] lcd8_in;       // narrow lcd view of the pads
  wire [7:0]  pp_gp_out;     // gpio 31:27 and 20:18
  wire [7:0]  pp_gp_oe;      // their enables

  // ========================================================
  // routing functions
  // parallel port source picked by mode, shared by out and oe
  function [20:0] pp_route;
    input [2:0]  mode;
    input [20:0] lcd;
    input [6:0]  spi;
    input [7:0]  gpio;
    input [3:0]  uart;
    input [3:0]  as3;
    input [3:0]  as4;
    begin
      case (mode)
        `PP_MODE_LCD16: pp_route = lcd;
        `PP_MODE_SPI_GPIO: pp_route = {as3, uart, gpio[5:0], spi};
        `PP_MODE_LCD8_GPIO: pp_route = {lcd[20:16], gpio, lcd[7:0]};
        `PP_MODE_LCD8_SPI_AS4:
          pp_route = {lcd[20:16], as4, spi[3:0], lcd[7:0]};
        `PP_MODE_LCD8_AS3_UART:
          pp_route = {lcd[20:16], uart, as3, lcd[7:0]};
        `PP_MODE_LCD8_SPI_UART:
          pp_route = {lcd[20:16], uart, spi[3:0], lcd[7:0]};
        `PP_MODE_SPI_AS_GPIO: pp_route = {gpio[5:0], as4, as3, spi};
        default: pp_route = 21'h000000;
      endcase
    end
  endfunction
  // serial port source, used for both ports, out and oe
  function [5:0] sp_route;
    input [1:0] mode;
    input [5:0] card;
    input [3:0] audio;
    input [5:0] gpio;
    case (mode)
      `SP_MODE_CARD: sp_route = card;
      `SP_MODE_AUDIO_GPIO: sp_route = {gpio[5:4], audio};
      `SP_MODE_GPIO: sp_route = gpio;
      // reserved code leaves pads undriven
      default: sp_route = 6'h00;
    endcase
  endfunction

  // ========================================================
  // pad input synchroniser
  // pads are asynchronous, so inputs arrive two flops late
  pin_input_sync #(.WIDTH(33)) u_pin_sync (
    .sys_clk  (sys_clk),
    .resetn   (resetn),
    .async_in ({sp1_pin_in, sp0_pin_in, pp_pin_in}),
    .sync_out (pins_sync)
  );
  assign pp_in   = pins_sync[20:0];
  assign sp0_in  = pins_sync[26:21];
  assign sp1_in  = pins_sync[32:27];
  assign lcd8_in = {pp_in[20:16], 8'h00, pp_in[7:0]};

  // ========================================================
  // outward routing
  assign pp_gp_out = {gp_out[31:27], gp_out[20:18]};
  assign pp_gp_oe  = {gp_oe[31:27], gp_oe[20:18]};
  // routing is combinational from the stored field, so
  // a write at one edge steers the pins in the next cycle
  assign pp_pin_out = pp_route(pp_mode, lcd_out, spi_out, pp_gp_out,
                               uart_out, third_audio_serial_port_out,
                               fourth_audio_serial_port_out);
  assign pp_pin_oe  = pp_route(pp_mode, lcd_oe, spi_oe, pp_gp_oe,
                               uart_oe, third_audio_serial_port_oe,
                               fourth_audio_serial_port_oe);
  assign sp1_pin_out = sp_route(sp1_mode, second_card_interface_out,
                                second_audio_serial_port_out,
                                gp_out[11:6]);
  assign sp1_pin_oe  = sp_route(sp1_mode, second_card_interface_oe,
                                second_audio_serial_port_oe,
                                gp_oe[11:6]);
  assign sp0_pin_out = sp_route(sp0_mode, first_card_interface_out,
                                first_audio_serial_port_out,
                                gp_out[5:0]);
  assign sp0_pin_oe  = sp_route(sp0_mode, first_card_interface_oe,
                                first_audio_serial_port_oe,
                                gp_oe[5:0]);

  // ========================================================
  // inward routing, parallel port
  // unrouted peripherals see zero, never foreign pin activity
  always @* begin
    lcd_in                      = 21'h000000;
    spi_in                      = 7'h00;
    uart_in                     = 4'h0;
    third_audio_serial_port_in  = 4'h0;
    fourth_audio_serial_port_in = 4'h0;
    pp_gp_in                    = 8'h00;
    case (pp_mode)
      `PP_MODE_LCD16: lcd_in = pp_in;
      `PP_MODE_SPI_GPIO: begin
        spi_in                     = pp_in[6:0];
        pp_gp_in                   = {2'h0, pp_in[12:7]};
        uart_in                    = pp_in[16:13];
        third_audio_serial_port_in = pp_in[20:17];
      end
      `PP_MODE_LCD8_GPIO: begin
        lcd_in   = lcd8_in;
        pp_gp_in = pp_in[15:8];
      end
      `PP_MODE_LCD8_SPI_AS4: begin
        lcd_in                      = lcd8_in;
        spi_in                      = {3'h0, pp_in[11:8]};
        fourth_audio_serial_port_in = pp_in[15:12];
      end
      `PP_MODE_LCD8_AS3_UART: begin
        lcd_in                     = lcd8_in;
        third_audio_serial_port_in = pp_in[11:8];
        uart_in                    = pp_in[15:12];
      end
      `PP_MODE_LCD8_SPI_UART: begin
        lcd_in  = lcd8_in;
        spi_in  = {3'h0, pp_in[11:8]};
        uart_in = pp_in[15:12];
      end
      `PP_MODE_SPI_AS_GPIO: begin
        spi_in                      = pp_in[6:0];
        third_audio_serial_port_in  = pp_in[10:7];
        fourth_audio_serial_port_in = pp_in[14:11];
        pp_gp_in                    = {2'h0, pp_in[20:15]};
      end
      // reserved code, all inputs held at zero
      default: lcd_in = 21'h000000;
    endcase
  end

  // ========================================================
  // inward routing, serial ports
  always @* begin
    first_card_interface_in     = 6'h00;
    second_card_interface_in    = 6'h00;
    first_audio_serial_port_in  = 4'h0;
    second_audio_serial_port_in = 4'h0;
    sp0_gp_in                   = 6'h00;
    sp1_gp_in                   = 6'h00;
    case (sp1_mode)
      `SP_MODE_CARD:       second_card_interface_in = sp1_in;
      `SP_MODE_AUDIO_GPIO: begin
        second_audio_serial_port_in = sp1_in[3:0];
        sp1_gp_in                   = {sp1_in[5:4], 4'h0};
      end
      `SP_MODE_GPIO:       sp1_gp_in = sp1_in;
      default:             sp1_gp_in = 6'h00;
    endcase
    case (sp0_mode)
      `SP_MODE_CARD:       first_card_interface_in = sp0_in;
      `SP_MODE_AUDIO_GPIO: begin
        first_audio_serial_port_in = sp0_in[3:0];
        sp0_gp_in                  = {sp0_in[5:4], 4'h0};
      end
      `SP_MODE_GPIO:       sp0_gp_in = sp0_in;
      default:             sp0_gp_in = 6'h00;
    endcase
  end
  // gpio bits outside this block's pads read as zero
  assign gp_in = {pp_gp_in[7:3], 6'h00, pp_gp_in[2:0], 6'h00,
                  sp1_gp_in, sp0_gp_in};

  // ========================================================
  // register writes
  // no interlock: software gates and resets peripherals
  always @(posedge sys_clk) begin
    if (!resetn) begin
      pp_mode    <= `PP_FIELD_RESET;
      sp1_mode   <= `SP_FIELD_RESET;
      sp0_mode   <= `SP_FIELD_RESET;
      core_vsel  <= `CORE_VSEL_RESET;
      usb_reg_en <= `USB_REG_EN_RESET;
      byte_sel   <= `BYTE_SEL_RESET;
    end else if (io_wr_en) begin
      case (io_addr)
        `PIN_ROUTE_ADDR: begin
          pp_mode  <= io_wdata[`PP_FIELD_MSB:`PP_FIELD_LSB];
          sp1_mode <= io_wdata[`SP1_FIELD_MSB:`SP1_FIELD_LSB];
          sp0_mode <= io_wdata[`SP0_FIELD_MSB:`SP0_FIELD_LSB];
        end
        `USB_CTRL_ADDR: byte_sel <= io_wdata[`BYTE_SEL_MSB:`BYTE_SEL_LSB];
        `REG_CTRL_ADDR: begin
          core_vsel  <= io_wdata[`CORE_VSEL_BIT];
          usb_reg_en <= io_wdata[`USB_REG_EN_BIT];
        end
        // unmapped write ignored
        default: ;
      endcase
    end
  end

  // ========================================================
  // register reads
  always @* begin
    next_rdata = 16'h0000;
    case (io_addr)
      `PIN_ROUTE_ADDR: begin
        next_rdata[`PP_FIELD_MSB:`PP_FIELD_LSB]   = pp_mode;
        next_rdata[`SP1_FIELD_MSB:`SP1_FIELD_LSB] = sp1_mode;
        next_rdata[`SP0_FIELD_MSB:`SP0_FIELD_LSB] = sp0_mode;
      end
      `USB_CTRL_ADDR: next_rdata[`BYTE_SEL_MSB:`BYTE_SEL_LSB] = byte_sel;
      `REG_CTRL_ADDR: begin
        next_rdata[`CORE_VSEL_BIT]  = core_vsel;
        next_rdata[`USB_REG_EN_BIT] = usb_reg_en;
      end
      // unmapped reads return zero
      default: next_rdata = 16'h0000;
    endcase
  end
  // read data registered, valid one cycle after the strobe
  always @(posedge sys_clk) begin
    if (!resetn) begin
      io_rdata    <= 16'h0000;
      io_rd_valid <= 1'b0;
    end else begin
      io_rd_valid <= io_rd_en;
      if (io_rd_en) begin
        io_rdata <= next_rdata;
      end
    end
  end

  // ========================================================
  // configuration outputs
  assign parallel_port_route_field     = pp_mode;
  assign serial_port_one_route_field   = sp1_mode;
  assign serial_port_zero_route_field  = sp0_mode;
  assign core_regulator_voltage_select = core_vsel;
  assign usb_regulator_enable          = usb_reg_en;
  assign usb_byte_access_select        = byte_sel;

endmodule

// ---- rtl/pin_routing_consts.vh ----
// constants for the external pin routing block
`ifndef PIN_ROUTING_CONSTS_VH
`define PIN_ROUTING_CONSTS_VH

// ==========================================================
// register port addresses
`define PIN_ROUTE_ADDR        16'h1C00
`define USB_CTRL_ADDR         16'h1C32
`define REG_CTRL_ADDR         16'h7004

// ==========================================================
// routing select field positions
`define PP_FIELD_MSB          14
`define PP_FIELD_LSB          12
`define SP1_FIELD_MSB         11
`define SP1_FIELD_LSB         10
`define SP0_FIELD_MSB         9
`define SP0_FIELD_LSB         8

// ==========================================================
// regulator and usb field positions
`define CORE_VSEL_BIT         1
`define USB_REG_EN_BIT        0
`define BYTE_SEL_MSB          1
`define BYTE_SEL_LSB          0

// ==========================================================
// reset values
`define PP_FIELD_RESET        3'h0
`define SP_FIELD_RESET        2'h0
`define CORE_VSEL_RESET       1'h0
`define USB_REG_EN_RESET      1'h0
`define BYTE_SEL_RESET        2'h0

// ==========================================================
// parallel port mode codes
`define PP_MODE_LCD16         3'h0
`define PP_MODE_SPI_GPIO      3'h1
`define PP_MODE_LCD8_GPIO     3'h2
`define PP_MODE_LCD8_SPI_AS4  3'h3
`define PP_MODE_LCD8_AS3_UART 3'h4
`define PP_MODE_LCD8_SPI_UART 3'h5
`define PP_MODE_SPI_AS_GPIO   3'h6

// ==========================================================
// serial port mode codes
`define SP_MODE_CARD          2'h0
`define SP_MODE_AUDIO_GPIO    2'h1
`define SP_MODE_GPIO          2'h2

// ==========================================================
// usb byte access codes
`define BYTE_SEL_WORD         2'h0
`define BYTE_SEL_HIGH         2'h1
`define BYTE_SEL_LOW          2'h2

`endif

// ---- rtl/pin_input_sync.v ----
// two flip-flop synchroniser for pad inputs
`timescale 1ns/1ps

module pin_input_sync #(
  parameter WIDTH = 33
) (
  input  wire             sys_clk,
  input  wire             resetn,
  input  wire [WIDTH-1:0] async_in,
  output reg  [WIDTH-1:0] sync_out
);

  // ========================================================
  // synchroniser stages
  reg [WIDTH-1:0] meta;  // first stage, read only by sync_out

  // both stages clear on reset so pins read low until valid
  always @(posedge sys_clk) begin
    if (!resetn) begin
      meta     <= {WIDTH{1'b0}};
      sync_out <= {WIDTH{1'b0}};
    end else begin
      meta     <= async_in;
      sync_out <= meta;
    end
  end

endmodule

// ---- tb/pin_routing_props.sv ----
// concurrent checks on the pin routing block ports
`timescale 1ns/1ps

module pin_routing_props (
  input logic        sys_clk,
  input logic        resetn,
  input logic [15:0] io_addr,
  input logic        io_wr_en,
  input logic        io_rd_en,
  input logic [15:0] io_wdata,
  input logic [15:0] io_rdata,
  input logic        io_rd_valid,
  input logic [20:0] pp_pin_out,
  input logic [20:0] lcd_out,
  input logic [5:0]  sp0_pin_out,
  input logic [5:0]  sp1_pin_out,
  input logic [5:0]  first_card_interface_out,
  input logic [5:0]  second_card_interface_out,
  input logic [31:0] gp_out,
  input logic [2:0]  parallel_port_route_field,
  input logic [1:0]  serial_port_one_route_field,
  input logic [1:0]  serial_port_zero_route_field,
  input logic        core_regulator_voltage_select,
  input logic        usb_regulator_enable,
  input logic [1:0]  usb_byte_access_select
);
  // ==========================================================
  // helper: last write data, avoids part-selects inside $past
  logic [15:0] last_wdata;
  always_ff @(posedge sys_clk) last_wdata <= io_wdata;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  // ==========================================================
  // register side
  route_write_a: assert property (
    io_wr_en && io_addr == 16'h1C00 |=> {parallel_port_route_field,
    serial_port_one_route_field, serial_port_zero_route_field}
    == last_wdata[14:8]) else $error("route fields missed a write");
  route_hold_a: assert property (
    !io_wr_en |=> $stable(parallel_port_route_field)
    && $stable(serial_port_one_route_field)
    && $stable(serial_port_zero_route_field))
    else $error("route field moved without a write");
  read_pulse_a: assert property (
    io_rd_en ##1 !io_rd_en |-> io_rd_valid ##1 !io_rd_valid)
    else $error("read valid is not a one cycle pulse");
  route_readback_a: assert property (
    io_rd_en && !io_wr_en && io_addr == 16'h1C00 |=> io_rdata ==
    {1'b0, parallel_port_route_field, serial_port_one_route_field,
    serial_port_zero_route_field, 8'h00})
    else $error("route readback wrong or reserved bit set");
  regulator_write_a: assert property (
    io_wr_en && io_addr == 16'h7004 |=> {core_regulator_voltage_select,
    usb_regulator_enable} == last_wdata[1:0])
    else $error("regulator bits missed a write");
  byte_select_a: assert property (
    io_wr_en && io_addr == 16'h1C32 |=>
    usb_byte_access_select == last_wdata[1:0])
    else $error("byte select missed a write");
  reset_values_a: assert property (
    $rose(resetn) |-> parallel_port_route_field == 3'h0
    && !core_regulator_voltage_select && !usb_regulator_enable
    && usb_byte_access_select == 2'h0)
    else $error("config not at reset value");
  // ==========================================================
  // pin routing side
  lcd_wide_a: assert property (
    parallel_port_route_field == 3'h0 |-> pp_pin_out == lcd_out)
    else $error("wide lcd routing wrong");
  lcd_narrow_a: assert property (
    parallel_port_route_field == 3'h2 |-> pp_pin_out[7:0] == lcd_out[7:0]
    && pp_pin_out[20:16] == lcd_out[20:16])
    else $error("narrow lcd routing wrong");
  card_zero_a: assert property (
    serial_port_zero_route_field == 2'h0 |->
    sp0_pin_out == first_card_interface_out)
    else $error("first card routing wrong");
  card_one_a: assert property (
    serial_port_one_route_field == 2'h0 |->
    sp1_pin_out == second_card_interface_out)
    else $error("second card routing wrong");
  gpio_zero_a: assert property (
    serial_port_zero_route_field == 2'h2 |-> sp0_pin_out == gp_out[5:0])
    else $error("serial zero gpio routing wrong");
  gpio_one_a: assert property (
    serial_port_one_route_field == 2'h2 |-> sp1_pin_out == gp_out[11:6])
    else $error("serial one gpio routing wrong");
endmodule

bind external_bus_pin_routing pin_routing_props i_pin_routing_props (.*);

// ---- tb/external_bus_pin_routing_tb_top.sv ----
// self-checking bench for the external pin routing block
`timescale 1ns/1ps

module external_bus_pin_routing_tb_top;
  // ==========================================================
  // clock, reset, register port
  logic        sys_clk = 1'b0;
  logic        resetn = 1'b0;
  logic [15:0] io_addr = 16'h0000, io_wdata = 16'h0000, io_rdata;
  logic        io_wr_en = 1'b0, io_rd_en = 1'b0, io_rd_valid;
  // pads and peripherals
  logic [20:0] pp_pin_in, pp_pin_out, pp_pin_oe, lcd_out, lcd_oe, lcd_in;
  logic [5:0]  sp0_pin_in, sp0_pin_out, sp0_pin_oe;
  logic [5:0]  sp1_pin_in, sp1_pin_out, sp1_pin_oe;
  logic [6:0]  spi_out, spi_oe, spi_in;
  logic [3:0]  uart_out, uart_oe, uart_in;
  logic [3:0]  first_audio_serial_port_out, first_audio_serial_port_oe;
  logic [3:0]  second_audio_serial_port_out, second_audio_serial_port_oe;
  logic [3:0]  third_audio_serial_port_out, third_audio_serial_port_oe;
  logic [3:0]  fourth_audio_serial_port_out, fourth_audio_serial_port_oe;
  logic [3:0]  first_audio_serial_port_in, second_audio_serial_port_in;
  logic [3:0]  third_audio_serial_port_in, fourth_audio_serial_port_in;
  logic [5:0]  first_card_interface_out, first_card_interface_oe;
  logic [5:0]  second_card_interface_out, second_card_interface_oe;
  logic [5:0]  first_card_interface_in, second_card_interface_in;
  logic [31:0] gp_out, gp_oe, gp_in;
  logic [2:0]  parallel_port_route_field;
  logic [1:0]  serial_port_one_route_field, serial_port_zero_route_field;
  logic [1:0]  usb_byte_access_select;
  logic        core_regulator_voltage_select, usb_regulator_enable;
  // bench model state and counters
  logic [15:0] exp_route, exp_usb, exp_reg, w;
  int          n_errors = 0, checks_done = 0, cycles = 0;

  external_bus_pin_routing i_external_bus_pin_routing (.*);

  // ==========================================================
  // clock and hang guard (run needs well under 1000 cycles)
  always #5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 3000) begin
      n_errors++;
      $display("Error at %0t: run did not finish", $time);
      complete_run();
    end
  end

  // ==========================================================
  // model: pad map for one parallel mode, unrouted codes give 0
  function automatic logic [20:0] pp_map(input logic [2:0] m,
    input logic [20:0] l, input logic [6:0] s, input logic [3:0] u,
    input logic [3:0] a3, input logic [3:0] a4, input logic [7:0] g);
    case (m)
      3'h0: return l;
      3'h1: return {a3, u, g[5:0], s};
      3'h2: return {l[20:16], g, l[7:0]};
      3'h3: return {l[20:16], a4, s[3:0], l[7:0]};
      3'h4: return {l[20:16], u, a3, l[7:0]};
      3'h5: return {l[20:16], u, s[3:0], l[7:0]};
      3'h6: return {g[5:0], a4, a3, s};
      default: return 21'h000000;
    endcase
  endfunction
  function automatic logic [5:0] sp_map(input logic [1:0] m,
    input logic [5:0] c, input logic [3:0] a, input logic [5:0] g);
    case (m)
      2'h0: return c;
      2'h1: return {g[5:4], a};
      2'h2: return g;
      default: return 6'h00;
    endcase
  endfunction
  function automatic logic [15:0] model_rd(input logic [15:0] a);
    case (a)
      16'h1C00: return exp_route;
      16'h1C32: return exp_usb;
      16'h7004: return exp_reg;
      default: return 16'h0000;
    endcase
  endfunction

  // ==========================================================
  // shared tasks
  task automatic check(input logic [31:0] got, input logic [31:0] exp,
                       input string what);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic rnd_inputs();
    {lcd_out, lcd_oe, spi_out, spi_oe, uart_out, uart_oe}
      = {$urandom, $urandom};
    {first_audio_serial_port_out, first_audio_serial_port_oe,
     second_audio_serial_port_out, second_audio_serial_port_oe,
     third_audio_serial_port_out, third_audio_serial_port_oe,
     fourth_audio_serial_port_out, fourth_audio_serial_port_oe} = $urandom;
    {first_card_interface_out, first_card_interface_oe, pp_pin_in,
     second_card_interface_out, second_card_interface_oe, sp0_pin_in,
     sp1_pin_in} = 57'({$urandom, $urandom});
    gp_out = $urandom;
    gp_oe = $urandom;
  endtask
  task automatic chk_cfg();
    check({parallel_port_route_field, serial_port_one_route_field,
           serial_port_zero_route_field}, exp_route[14:8], "fields");
    check({core_regulator_voltage_select, usb_regulator_enable},
          exp_reg, "regulator bits");
    check(usb_byte_access_select, exp_usb, "byte select");
  endtask
  task automatic chk_pins();
    logic [7:0] go, ge;
    go = {gp_out[31:27], gp_out[20:18]};
    ge = {gp_oe[31:27], gp_oe[20:18]};
    check(pp_pin_out, pp_map(exp_route[14:12], lcd_out, spi_out, uart_out,
      third_audio_serial_port_out, fourth_audio_serial_port_out, go), "pp");
    check(pp_pin_oe, pp_map(exp_route[14:12], lcd_oe, spi_oe, uart_oe,
      third_audio_serial_port_oe, fourth_audio_serial_port_oe, ge), "ppoe");
    check(sp0_pin_out, sp_map(exp_route[9:8], first_card_interface_out,
      first_audio_serial_port_out, gp_out[5:0]), "sp0");
    check(sp0_pin_oe, sp_map(exp_route[9:8], first_card_interface_oe,
      first_audio_serial_port_oe, gp_oe[5:0]), "sp0 oe");
    check(sp1_pin_out, sp_map(exp_route[11:10], second_card_interface_out,
      second_audio_serial_port_out, gp_out[11:6]), "sp1");
    check(sp1_pin_oe, sp_map(exp_route[11:10], second_card_interface_oe,
      second_audio_serial_port_oe, gp_oe[11:6]), "sp1 oe");
  endtask
  // every pad comes back intact through the mirrored map
  task automatic chk_in();
    check(pp_map(exp_route[14:12], lcd_in, spi_in, uart_in,
      third_audio_serial_port_in, fourth_audio_serial_port_in,
      {gp_in[31:27], gp_in[20:18]}), pp_pin_in, "pp in");
    check(sp_map(exp_route[9:8], first_card_interface_in,
      first_audio_serial_port_in, gp_in[5:0]), sp0_pin_in, "sp0 in");
    check(sp_map(exp_route[11:10], second_card_interface_in,
      second_audio_serial_port_in, gp_in[11:6]), sp1_pin_in, "sp1 in");
    check({gp_in[26:21], gp_in[17:12]}, 32'h0, "gp unused");
  endtask
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge sys_clk) #1;
    io_addr = a;
    io_wdata = d;
    io_wr_en = 1'b1;
    @(posedge sys_clk) #1;
    io_wr_en = 1'b0;
    case (a) // reserved bits are not kept
      16'h1C00: exp_route = d & 16'h7F00;
      16'h1C32: exp_usb = d & 16'h0003;
      16'h7004: exp_reg = d & 16'h0003;
      default: ;
    endcase
    chk_cfg();
  endtask
  task automatic rd(input logic [15:0] a);
    @(posedge sys_clk) #1;
    io_addr = a;
    io_rd_en = 1'b1;
    @(posedge sys_clk) #1;
    io_rd_en = 1'b0;
    check(io_rd_valid, 32'h1, "read valid");
    check(io_rdata, model_rd(a), "read data");
  endtask
  task automatic complete_run();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // ==========================================================
  // main sequence
  initial begin
    void'($urandom(32'hEB9F));
    rnd_inputs();
    {exp_route, exp_usb, exp_reg} = 48'h0;
    repeat (16) @(posedge sys_clk);
    #1 resetn = 1'b1;
    chk_cfg();
    rd(16'h1C00);
    rd(16'h1C32);
    rd(16'h7004);
    chk_pins();
    $display("test reset values done");
    wr(16'h7004, 16'hFFFF);
    wr(16'h7004, 16'h0002);
    rd(16'h7004);
    for (int b = 0; b < 3; b++) begin
      wr(16'h1C32, {14'($urandom), 2'(b)});
      rd(16'h1C32);
    end
    wr(16'h1C01, 16'hFFFF);
    rd(16'h1C01);
    rd(16'h1C00);
    $display("test config registers done");
    // every mode code, junk in reserved bits, fresh peripheral data
    for (int i = 0; i < 42; i++) begin
      rnd_inputs(); // peripherals and pads get fresh random data
      w = 16'($urandom) & 16'h80FF;
      w[14:8] = {3'(i % 7), 2'(i % 3), 2'((i / 3) % 3)};
      wr(16'h1C00, w);
      chk_pins();
      rd(16'h1C00);
      chk_in();
    end
    $display("test routing modes done");
    // second reset in mid-run returns defaults
    wr(16'h1C00, 16'h6A00);
    chk_pins();
    wr(16'h7004, 16'h0003);
    @(posedge sys_clk) #1 resetn = 1'b0;
    repeat (2) @(posedge sys_clk);
    #1 resetn = 1'b1;
    {exp_route, exp_usb, exp_reg} = 48'h0;
    chk_cfg();
    chk_pins();
    rd(16'h1C00);
    $display("test second reset done");
    complete_run();
  end
endmodule
